// ===== design/rscf_pkg.sv
package rscf_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] WDCTL_ADDR   = 8'hD8;
  localparam logic [7:0] UNLOCK_ADDR  = 8'hC7;
  localparam logic [7:0] IRQ_ST_ADDR  = 8'hE0;
  localparam logic [7:0] IRQ_MSK_ADDR = 8'hE1;

  // ==========================================================
  // Watchdog control/status field positions
  localparam int WD_RUN_BIT  = 7;
  localparam int WD_RSV_BIT  = 6;
  localparam int WD_SEL_HI   = 5;
  localparam int WD_SEL_LO   = 4;
  localparam int WD_IF_BIT   = 3;
  localparam int WD_CAUSE    = 2;
  localparam int WD_RST_EN   = 1;
  localparam int WD_CLR_BIT  = 0;

  // Bits that need the unlock sequence before a write lands
  localparam logic [7:0] WD_GUARD_MASK = 8'hBB;
  localparam logic [7:0] WDCTL_RST     = 8'h00;

  // ==========================================================
  // Core reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0]  SP_RST = 8'h07;

  // ==========================================================
  // Unlock sequence
  localparam logic [7:0] UNLOCK_KEY1 = 8'hAA;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h55;
  localparam int         UNLOCK_NS   = 30;
  localparam int         CLK_NS      = 10;
  localparam logic [2:0] UNLOCK_CYC  = 3'((UNLOCK_NS / CLK_NS));

  // ==========================================================
  // Interrupt status layout
  localparam int IRQ_W        = 3;
  localparam int IRQ_TIMEOUT  = 0;
  localparam int IRQ_WAKE     = 1;
  localparam int IRQ_WDRESET  = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  typedef enum logic [2:0] {
    UL_IDLE = 3'b001,
    UL_HALF = 3'b010,
    UL_OPEN = 3'b100
  } rscf_unlock_t;

endpackage

// ===== design/rscf_reset_state.sv
`timescale 1ns/1ps

module rscf_reset_state (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        pd_reset_i,
  input  wire logic        wdt_reset_i,
  input  wire logic        ext_reset_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        ram_we_i,
  input  wire logic        wd_counting_i,
  input  wire logic        wd_timeout_i,
  input  wire logic        wd_clk_rc_i,
  input  wire logic        adc_done_i,
  input  wire logic        adc_clk_rc_i,
  input  wire logic        adc_cmp_i,
  input  wire logic        power_down_i,
  output logic [7:0]       rdata_o,
  output logic             core_hold_o,
  output logic [15:0]      pc_force_o,
  output logic             sp_load_o,
  output logic [7:0]       sp_value_o,
  output logic             ram_we_o,
  output logic             wd_run_o,
  output logic [1:0]       wd_interval_o,
  output logic             wd_reset_en_o,
  output logic             wd_clear_o,
  output logic             wake_o,
  output logic             irq_o
);

  // ==========================================================
  // Address decode shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction

  logic       por_w;
  logic       any_rst_w;
  logic       wr_wd_w;
  logic       wr_ul_w;
  logic       wr_st_w;
  logic       wr_mk_w;
  logic       guard_open_w;
  logic       wake_ev_w;

  assign por_w     = reset_i | pd_reset_i;
  assign any_rst_w = por_w | wdt_reset_i | ext_reset_i;
  assign wr_wd_w   = wr_i & hit(addr_i, rscf_pkg::WDCTL_ADDR);
  assign wr_ul_w   = wr_i & hit(addr_i, rscf_pkg::UNLOCK_ADDR);
  assign wr_st_w   = wr_i & hit(addr_i, rscf_pkg::IRQ_ST_ADDR);
  assign wr_mk_w   = wr_i & hit(addr_i, rscf_pkg::IRQ_MSK_ADDR);

  // ==========================================================
  // Core hold, pc and stack pointer forcing
  logic        core_hold_ff, nxt_core_hold;
  logic        sp_load_ff, nxt_sp_load;
  logic        ram_we_ff, nxt_ram_we;

  // RAM contents are never touched; writes are only blocked while held
  always_comb begin
    nxt_core_hold = any_rst_w;
    nxt_sp_load   = any_rst_w;
    nxt_ram_we    = ram_we_i & ~any_rst_w;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      core_hold_ff <= 1'b1;
      sp_load_ff   <= 1'b1;
      ram_we_ff    <= 1'b0;
    end else begin
      core_hold_ff <= nxt_core_hold;
      sp_load_ff   <= nxt_sp_load;
      ram_we_ff    <= nxt_ram_we;
    end
  end

  // ==========================================================
  // Unlock sequencer: key1 then key2, then a short open window
  rscf_pkg::rscf_unlock_t ul_state_ff, nxt_ul_state;
  logic [2:0]             ul_cnt_ff, nxt_ul_cnt;

  always_comb begin
    nxt_ul_state = ul_state_ff;
    nxt_ul_cnt   = (ul_cnt_ff != 3'h0) ? ul_cnt_ff - 3'h1 : 3'h0;
    case (ul_state_ff)
      rscf_pkg::UL_IDLE: begin
        if (wr_ul_w && wdata_i == rscf_pkg::UNLOCK_KEY1) begin
          nxt_ul_state = rscf_pkg::UL_HALF;
          nxt_ul_cnt   = rscf_pkg::UNLOCK_CYC;
        end
      end
      rscf_pkg::UL_HALF: begin
        if (wr_ul_w && wdata_i == rscf_pkg::UNLOCK_KEY2) begin
          nxt_ul_state = rscf_pkg::UL_OPEN;
          nxt_ul_cnt   = rscf_pkg::UNLOCK_CYC;
        end else if (wr_ul_w || ul_cnt_ff == 3'h0) begin
          nxt_ul_state = rscf_pkg::UL_IDLE;
        end
      end
      rscf_pkg::UL_OPEN: begin
        // One guarded write per unlock; a stale window closes itself
        if (wr_wd_w || ul_cnt_ff == 3'h0) begin
          nxt_ul_state = rscf_pkg::UL_IDLE;
        end
      end
      default: nxt_ul_state = rscf_pkg::UL_IDLE;
    endcase
    if (any_rst_w) begin
      nxt_ul_state = rscf_pkg::UL_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ul_state_ff <= rscf_pkg::UL_IDLE;
      ul_cnt_ff   <= 3'h0;
    end else begin
      ul_state_ff <= nxt_ul_state;
      ul_cnt_ff   <= nxt_ul_cnt;
    end
  end

  assign guard_open_w = (ul_state_ff == rscf_pkg::UL_OPEN) && (ul_cnt_ff != 3'h0);

  // ==========================================================
  // Watchdog control/status register
  logic [7:0] wdctl_ff, nxt_wdctl;
  logic       clr_pulse_ff, nxt_clr_pulse;
  logic       counting_ff;

  always_comb begin
    nxt_wdctl     = wdctl_ff;
    nxt_clr_pulse = 1'b0;
    if (wd_timeout_i) begin
      nxt_wdctl[rscf_pkg::WD_IF_BIT] = 1'b1;
    end
    if (wr_wd_w) begin
      // Free bit lands always; guarded ones only inside the window
      nxt_wdctl[rscf_pkg::WD_CAUSE] = wdata_i[rscf_pkg::WD_CAUSE];
      if (guard_open_w) begin
        nxt_wdctl[rscf_pkg::WD_RUN_BIT] = wdata_i[rscf_pkg::WD_RUN_BIT];
        nxt_wdctl[rscf_pkg::WD_SEL_HI]  = wdata_i[rscf_pkg::WD_SEL_HI];
        nxt_wdctl[rscf_pkg::WD_SEL_LO]  = wdata_i[rscf_pkg::WD_SEL_LO];
        nxt_wdctl[rscf_pkg::WD_RST_EN]  = wdata_i[rscf_pkg::WD_RST_EN];
        // Timeout in the same cycle as a clear keeps the flag set
        nxt_wdctl[rscf_pkg::WD_IF_BIT]  = wdata_i[rscf_pkg::WD_IF_BIT] | wd_timeout_i;
        nxt_clr_pulse                   = wdata_i[rscf_pkg::WD_CLR_BIT];
      end
    end
    nxt_wdctl[rscf_pkg::WD_RSV_BIT] = 1'b0;
    nxt_wdctl[rscf_pkg::WD_CLR_BIT] = 1'b0;
    // Source-dependent reset value, power-on wins over the others
    if (por_w) begin
      nxt_wdctl = rscf_pkg::WDCTL_RST;
    end else if (wdt_reset_i) begin
      nxt_wdctl                     = rscf_pkg::WDCTL_RST;
      nxt_wdctl[rscf_pkg::WD_CAUSE] = 1'b1;
    end else if (ext_reset_i) begin
      nxt_wdctl                     = rscf_pkg::WDCTL_RST;
      nxt_wdctl[rscf_pkg::WD_CAUSE] = wdctl_ff[rscf_pkg::WD_CAUSE];
    end
    if (any_rst_w) begin
      nxt_clr_pulse = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdctl_ff     <= rscf_pkg::WDCTL_RST;
      clr_pulse_ff <= 1'b0;
      counting_ff  <= 1'b0;
    end else begin
      wdctl_ff     <= nxt_wdctl;
      clr_pulse_ff <= nxt_clr_pulse;
      counting_ff  <= wd_counting_i;
    end
  end

  // ==========================================================
  // Power-down wake sources; compare event is deliberately absent
  logic wake_ff;

  assign wake_ev_w = power_down_i & ((wd_timeout_i & wd_clk_rc_i)
                                   | (adc_done_i & adc_clk_rc_i));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= wake_ev_w;
    end
  end

  // ==========================================================
  // Sticky interrupt status, write one to clear, set wins
  logic [rscf_pkg::IRQ_W-1:0] st_ff, nxt_st;
  logic [rscf_pkg::IRQ_W-1:0] mk_ff, nxt_mk;
  logic [rscf_pkg::IRQ_W-1:0] ev_w;
  logic                       irq_ff, nxt_irq;

  always_comb begin
    ev_w                         = '0;
    ev_w[rscf_pkg::IRQ_TIMEOUT]  = wd_timeout_i;
    ev_w[rscf_pkg::IRQ_WAKE]     = wake_ev_w;
    ev_w[rscf_pkg::IRQ_WDRESET]  = wdt_reset_i;
    nxt_mk = wr_mk_w ? wdata_i[rscf_pkg::IRQ_W-1:0] : mk_ff;
    for (int i = 0; i < rscf_pkg::IRQ_W; i++) begin
      nxt_st[i] = ev_w[i] | (st_ff[i] & ~(wr_st_w & wdata_i[i]));
    end
    nxt_irq = |(nxt_st & nxt_mk);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff  <= rscf_pkg::IRQ_RST;
      mk_ff  <= rscf_pkg::IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      mk_ff  <= nxt_mk;
      irq_ff <= nxt_irq;
    end
  end

  // ==========================================================
  // Read port, data valid in the cycle after the strobe
  logic [7:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
      if (hit(addr_i, rscf_pkg::WDCTL_ADDR)) begin
        nxt_rdata = wdctl_ff;
        nxt_rdata[rscf_pkg::WD_RUN_BIT] = counting_ff;
      end else if (hit(addr_i, rscf_pkg::IRQ_ST_ADDR)) begin
        nxt_rdata = {5'h00, st_ff};
      end else if (hit(addr_i, rscf_pkg::IRQ_MSK_ADDR)) begin
        nxt_rdata = {5'h00, mk_ff};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // Outputs, all from flops except the constant pc_force_o and sp_value_o
  assign rdata_o       = rdata_ff;
  assign core_hold_o   = core_hold_ff;
  assign pc_force_o    = rscf_pkg::PC_RST;
  assign sp_load_o     = sp_load_ff;
  assign sp_value_o    = rscf_pkg::SP_RST;
  assign ram_we_o      = ram_we_ff;
  assign wd_run_o      = wdctl_ff[rscf_pkg::WD_RUN_BIT];
  assign wd_interval_o = wdctl_ff[rscf_pkg::WD_SEL_HI:rscf_pkg::WD_SEL_LO];
  assign wd_reset_en_o = wdctl_ff[rscf_pkg::WD_RST_EN];
  assign wd_clear_o    = clr_pulse_ff;
  assign wake_o        = wake_ff;
  assign irq_o         = irq_ff;

  // ==========================================================
  // Checks
  a_hold_in_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    any_rst_w |=> core_hold_o && sp_load_o && pc_force_o == 16'h0000)
    else $error("core not held during reset");
  a_ram_blocked: assert property (@(posedge clk_i) disable iff (reset_i)
    any_rst_w |=> !ram_we_o)
    else $error("ram write during reset");
  a_sp_value: assert property (@(posedge clk_i) disable iff (reset_i)
    sp_load_o |-> sp_value_o == 8'h07)
    else $error("stack pointer reset value wrong");
  a_wdt_cause: assert property (@(posedge clk_i) disable iff (reset_i)
    wdt_reset_i && !por_w |=> wdctl_ff == 8'h04)
    else $error("watchdog reset value wrong");
  a_por_value: assert property (@(posedge clk_i) disable iff (reset_i)
    pd_reset_i |=> wdctl_ff == rscf_pkg::WDCTL_RST)
    else $error("power reset value wrong");
  a_ext_keeps: assert property (@(posedge clk_i) disable iff (reset_i)
    ext_reset_i && !por_w && !wdt_reset_i |=> wdctl_ff[2] == $past(wdctl_ff[2]) && wdctl_ff[1] == 1'b0)
    else $error("external reset changed cause flag");
  a_flag_cleared: assert property (@(posedge clk_i) disable iff (reset_i)
    any_rst_w |=> !wd_reset_en_o && !wdctl_ff[3])
    else $error("reset left enable or flag set");
  a_guard_locked: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_wd_w && !guard_open_w && !any_rst_w && !wd_timeout_i
      |=> (wdctl_ff & rscf_pkg::WD_GUARD_MASK) == ($past(wdctl_ff) & rscf_pkg::WD_GUARD_MASK))
    else $error("guarded bit written while locked");
  a_no_cmp_wake: assert property (@(posedge clk_i) disable iff (reset_i)
    adc_cmp_i && !(wd_timeout_i && wd_clk_rc_i) && !(adc_done_i && adc_clk_rc_i) |=> !wake_o)
    else $error("compare event woke the device");
  a_wake_rc: assert property (@(posedge clk_i) disable iff (reset_i)
    power_down_i && wd_timeout_i && wd_clk_rc_i |=> wake_o)
    else $error("watchdog wake missing");
  a_run_read: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == 8'hD8 |-> ##1 rdata_o[7] == $past(counting_ff))
    else $error("running bit read wrong");

  c_unlock_write: cover property (@(posedge clk_i) disable iff (reset_i)
    guard_open_w && wr_wd_w);
  c_wdt_reset: cover property (@(posedge clk_i) disable iff (reset_i) wdt_reset_i ##1 !any_rst_w);
  c_wake: cover property (@(posedge clk_i) disable iff (reset_i) wake_o);

endmodule // rscf_reset_state

// ===== sim/rscf_reset_state_tb_top.sv
`timescale 1ns/1ps

module rscf_reset_state_tb_top;
  // ==========================================================
  // Signals
  logic        clk_i, reset_i, pd_reset_i, wdt_reset_i, ext_reset_i, wr_i, rd_i, ram_we_i;
  logic        wd_counting_i, wd_timeout_i, wd_clk_rc_i, adc_done_i, adc_clk_rc_i, adc_cmp_i, power_down_i;
  logic [7:0]  addr_i, wdata_i, rdata_o, sp_value_o, v, p;
  logic        core_hold_o, sp_load_o, ram_we_o, wd_run_o, wd_reset_en_o, wd_clear_o, wake_o, irq_o;
  logic [15:0] pc_force_o;
  logic [1:0]  wd_interval_o;
  logic [31:0] seed = 32'h3700_5d03;
  logic [31:0] r;
  logic [5:0]  corner [5] = '{6'h38, 6'h26, 6'h23, 6'h1e, 6'h30};
  int          failures = 0, n_checks = 0, n_clr = 0, n_wake = 0, w0;

  rscf_reset_state i_rscf_reset_state (.clk_i, .reset_i, .pd_reset_i, .wdt_reset_i, .ext_reset_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .ram_we_i, .wd_counting_i, .wd_timeout_i, .wd_clk_rc_i, .adc_done_i, .adc_clk_rc_i,
    .adc_cmp_i, .power_down_i, .rdata_o, .core_hold_o, .pc_force_o, .sp_load_o, .sp_value_o, .ram_we_o,
    .wd_run_o, .wd_interval_o, .wd_reset_en_o, .wd_clear_o, .wake_o, .irq_o);

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Pulse counters, so latency choices do not matter
  always @(posedge clk_i) begin
    if (wd_clear_o === 1'b1) n_clr++;
    if (wake_o === 1'b1) n_wake++;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Source 0 power, 1 power-down, 2 watchdog, 3 external
  function automatic logic [7:0] exp_rst(input int k, input logic [7:0] prev);
    return (k == 2) ? 8'h04 : (k == 3) ? (prev & 8'h04) : 8'h00;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Gap cycle between strobes keeps each signal to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic unlock();
    wr(rscf_pkg::UNLOCK_ADDR, rscf_pkg::UNLOCK_KEY1);
    wr(rscf_pkg::UNLOCK_ADDR, rscf_pkg::UNLOCK_KEY2);
  endtask

  task automatic src_rst(input int k);
    @(posedge clk_i);
    {reset_i, pd_reset_i, wdt_reset_i, ext_reset_i} <= 4'b1000 >> k;
    repeat (3) @(posedge clk_i);
    #1 chk(core_hold_o, 1'b1);
    chk(pc_force_o, rscf_pkg::PC_RST);
    chk({sp_load_o, sp_value_o}, {1'b1, rscf_pkg::SP_RST});
    chk(ram_we_o, 1'b0);
    @(posedge clk_i);
    {reset_i, pd_reset_i, wdt_reset_i, ext_reset_i} <= 4'b0000;
    repeat (2) @(posedge clk_i);
    #1 chk({core_hold_o, sp_load_o, ram_we_o}, 3'b001);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {reset_i, pd_reset_i, wdt_reset_i, ext_reset_i} = 4'b1000;
    {wr_i, rd_i, wd_timeout_i, wd_clk_rc_i, adc_done_i, adc_clk_rc_i, adc_cmp_i, power_down_i} = 8'h00;
    {addr_i, wdata_i} = 16'h0000;
    ram_we_i      = 1'b1;
    wd_counting_i = 1'b1;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    // Locked write: only the free bit lands
    wr(rscf_pkg::WDCTL_ADDR, 8'hff);
    rd(rscf_pkg::WDCTL_ADDR);
    chk(v, 8'h84);
    chk({wd_run_o, wd_interval_o, wd_reset_en_o, 12'(n_clr)}, 16'h0000);
    unlock();
    wr(rscf_pkg::WDCTL_ADDR, 8'hb3);
    wd_counting_i <= 1'b0;
    rd(rscf_pkg::WDCTL_ADDR);
    chk(v, 8'h32);
    chk({wd_run_o, wd_interval_o, wd_reset_en_o, 12'(n_clr)}, 16'hf001);
    // One write closes the window
    wr(rscf_pkg::WDCTL_ADDR, 8'h00);
    rd(rscf_pkg::WDCTL_ADDR);
    chk(v, 8'h32);
    // Timeout event, interrupt mask and clear
    wr(rscf_pkg::IRQ_MSK_ADDR, 8'h01);
    wd_timeout_i <= 1'b1;
    @(posedge clk_i);
    wd_timeout_i <= 1'b0;
    rd(rscf_pkg::WDCTL_ADDR);
    chk({v, irq_o}, {8'h3a, 1'b1});
    rd(rscf_pkg::IRQ_ST_ADDR);
    chk(v, 8'h01);
    wr(rscf_pkg::IRQ_MSK_ADDR, 8'h00);
    #1 chk(irq_o, 1'b0);
    wr(rscf_pkg::IRQ_ST_ADDR, 8'h01);
    wr(rscf_pkg::IRQ_MSK_ADDR, 8'h01);
    rd(rscf_pkg::IRQ_ST_ADDR);
    chk({v, irq_o}, 9'h000);
    // Flag clear needs the unlock too
    wr(rscf_pkg::WDCTL_ADDR, 8'h32);
    rd(rscf_pkg::WDCTL_ADDR);
    chk(v, 8'h3a);
    unlock();
    wr(rscf_pkg::WDCTL_ADDR, 8'hb2);
    rd(rscf_pkg::WDCTL_ADDR);
    chk(v, 8'h32);
    rd(8'h10);
    chk(v, 8'h00);
    // Every reset source with a random prior cause bit
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      unlock();
      wr(rscf_pkg::WDCTL_ADDR, 8'hba);
      wr(rscf_pkg::WDCTL_ADDR, r[7:0]);
      p = r[7:0] & 8'h04;
      wd_timeout_i <= 1'b1;
      @(posedge clk_i);
      wd_timeout_i <= 1'b0;
      src_rst(i % 4);
      rd(rscf_pkg::WDCTL_ADDR);
      chk(v, exp_rst(i % 4, p));
      chk({wd_reset_en_o, wd_interval_o, wd_run_o}, 4'h0);
    end
    // Wake from power-down: corners first, then random
    for (int i = 0; i < 30; i++) begin
      r  = rnd();
      w0 = n_wake;
      if (i < 5) r[5:0] = corner[i];
      @(posedge clk_i);
      {power_down_i, wd_timeout_i, wd_clk_rc_i, adc_done_i, adc_clk_rc_i, adc_cmp_i} <= r[5:0];
      @(posedge clk_i);
      {wd_timeout_i, adc_done_i, adc_cmp_i} <= 3'b000;
      repeat (4) @(posedge clk_i);
      chk(16'(n_wake - w0), {15'h0, r[5] & (r[4] & r[3] | r[2] & r[1])});
      chk(wake_o, 1'b0);
    end
    end_sim();
  end

  // Whole run needs about 450 cycles; this allows over forty times that
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule // rscf_reset_state_tb_top
